// ==== bsm_pkg.sv ====
// package of constants and carrier types for the bridge status mailbox flags block
// Contract
// RL1: status bit 12 mirrors config status bit 14
// RL2: writes to mirrored system-error flag ignored
// RL3: status bit 13 mirrors config status bit 15
// RL4: inbound mailbox n write sets bit 16+n
// RL5: mailbox flags stay set until one written
// RL6: read-only current status register at 0x306c
// RL7: current bit 3 shows live master enable
// RL8: target-only mode forces master enable zero
// RL9: interrupt status register sits at 0x3060
// RL10: set and enabled status bit raises interrupt
// RL11: reserved bits read zero, ignore writes
package bsm_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [13:0] ADDR_IRQ_STATUS  = 14'h3060;
   localparam logic [13:0] ADDR_CUR_STATUS  = 14'h306c;
   localparam logic [13:0] ADDR_IRQ_ENABLE  = 14'h3070;
   localparam int          ADDR_W           = 14;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int SERR_STATUS_BIT   = 12;
   localparam int PERR_STATUS_BIT   = 13;
   localparam int BOX_FLAG_LSB      = 16;
   localparam int NUM_BOXES         = 8;
   localparam int CFG_SERR_BIT      = 14;
   localparam int CFG_PERR_BIT      = 15;
   localparam int CMD_MASTER_EN_BIT = 2;
   localparam int CUR_MASTER_EN_BIT = 3;

   // implemented bits of the interrupt status and enable registers
   localparam logic [31:0] IRQ_IMPL_MASK = 32'h00ff_3000;
   localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

   // ***************************************************************
   // axi response codes
   // ***************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************************
   // carrier types
   // ***************************************************************
   typedef struct packed {
      logic [15:0] cfg_status;
      logic [15:0] cmd;
   } bsm_pci_cfg_type;

   typedef struct packed {
      logic [1:0]  resp;
      logic [31:0] data;
   } bsm_rd_answer_type;

endpackage

// ==== bsm_box_flags.sv ====
// sticky mailbox-written flags, write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module bsm_box_flags #(
   parameter int N = 8
) (
   // clock and reset
   input  wire logic         CORE_CLK_I,
   input  wire logic         RSTN_I,
   // events and clears
   input  wire logic [N-1:0] set_i,
   input  wire logic [N-1:0] clear_i,
   // flags
   output logic      [N-1:0] flag_o
);

   logic [N-1:0] flag;
   logic [N-1:0] next_flag;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_flag
         // set beats a clear in the same cycle
         assign next_flag[g] = set_i[g] | (flag[g] & ~clear_i[g]); // RL4 RL5
      end
   endgenerate

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         flag <= '0;
      end else begin
         flag <= next_flag;
      end
   end

   assign flag_o = flag;

endmodule

// ==== bsm_top.sv ====
// axi4-lite register bank for bridge interrupt status, enable and current pci status
`timescale 1ns/1ps
module bsm_top #(
   parameter bit TARGET_ONLY = 1'b0
) (
   // clock and reset
   input  wire logic                     CORE_CLK_I,
   input  wire logic                     RSTN_I,
   // pci side state, same clock
   input  wire bsm_pkg::bsm_pci_cfg_type PCI_CFG_I,
   input  wire logic [7:0]               BOX_WRITE_I,
   // write address channel
   input  wire logic                     AWVALID_I,
   output logic                          AWREADY_O,
   input  wire logic [31:0]              AWADDR_I,
   input  wire logic [2:0]               AWPROT_I,
   // write data channel
   input  wire logic                     WVALID_I,
   output logic                          WREADY_O,
   input  wire logic [31:0]              WDATA_I,
   input  wire logic [3:0]               WSTRB_I,
   // write response channel
   output logic                          BVALID_O,
   input  wire logic                     BREADY_I,
   output logic [1:0]                    BRESP_O,
   // read address channel
   input  wire logic                     ARVALID_I,
   output logic                          ARREADY_O,
   input  wire logic [31:0]              ARADDR_I,
   input  wire logic [2:0]               ARPROT_I,
   // read data channel
   output logic                          RVALID_O,
   input  wire logic                     RREADY_I,
   output logic [31:0]                   RDATA_O,
   output logic [1:0]                    RRESP_O,
   // interrupt
   output logic                          CTRL_IRQ_OUT_O
);

   // ***************************************************************
   // write path state
   // ***************************************************************
   logic                       aw_held;
   logic                       next_aw_held;
   logic [bsm_pkg::ADDR_W-1:0] aw_addr;
   logic [bsm_pkg::ADDR_W-1:0] next_aw_addr;
   logic                       w_held;
   logic                       next_w_held;
   logic [31:0]                w_data;
   logic [31:0]                next_w_data;
   logic [3:0]                 w_strb;
   logic [3:0]                 next_w_strb;
   logic                       bvalid;
   logic                       next_bvalid;
   logic [1:0]                 bresp;
   logic [1:0]                 next_bresp;
   logic [31:0]                irq_enable;
   logic [31:0]                next_irq_enable;
   logic                       wr_fire;
   logic [31:0]                wr_bits;
   logic [7:0]                 box_clear;
   logic [7:0]                 box_flag;

   // ***************************************************************
   // read path state
   // ***************************************************************
   logic                       rvalid;
   logic                       next_rvalid;
   bsm_pkg::bsm_rd_answer_type rd_answer;
   bsm_pkg::bsm_rd_answer_type next_rd_answer;

   // ***************************************************************
   // address decode
   // ***************************************************************
   logic wr_hit_status;
   logic wr_hit_enable;
   logic wr_hit_current;
   logic rd_hit_status;
   logic rd_hit_enable;
   logic rd_hit_current;
   logic rd_upper_zero;

   // writes decode the held low address bits only
   always_comb begin
      wr_hit_status  = aw_addr == bsm_pkg::ADDR_IRQ_STATUS; // RL9
      wr_hit_enable  = aw_addr == bsm_pkg::ADDR_IRQ_ENABLE;
      wr_hit_current = aw_addr == bsm_pkg::ADDR_CUR_STATUS; // RL6
   end

   // reads also demand zero in the upper address bits
   always_comb begin
      rd_hit_status  = ARADDR_I[bsm_pkg::ADDR_W-1:0] == bsm_pkg::ADDR_IRQ_STATUS; // RL9
      rd_hit_enable  = ARADDR_I[bsm_pkg::ADDR_W-1:0] == bsm_pkg::ADDR_IRQ_ENABLE;
      rd_hit_current = ARADDR_I[bsm_pkg::ADDR_W-1:0] == bsm_pkg::ADDR_CUR_STATUS; // RL6
      rd_upper_zero  = ARADDR_I[31:bsm_pkg::ADDR_W] == '0;
   end

   // ***************************************************************
   // live register views
   // ***************************************************************
   logic [31:0] irq_status;
   logic [31:0] cur_status;
   logic        master_en;

   always_comb begin
      irq_status = '0; // RL11
      irq_status[bsm_pkg::SERR_STATUS_BIT] =
         PCI_CFG_I.cfg_status[bsm_pkg::CFG_SERR_BIT]; // RL1 RL2
      irq_status[bsm_pkg::PERR_STATUS_BIT] =
         PCI_CFG_I.cfg_status[bsm_pkg::CFG_PERR_BIT]; // RL3
      irq_status[bsm_pkg::BOX_FLAG_LSB +: bsm_pkg::NUM_BOXES] = box_flag;
   end

   assign master_en = TARGET_ONLY ? 1'b0 : PCI_CFG_I.cmd[bsm_pkg::CMD_MASTER_EN_BIT]; // RL7 RL8

   always_comb begin
      cur_status = '0; // RL11
      cur_status[bsm_pkg::CUR_MASTER_EN_BIT] = master_en; // RL6 RL7
   end

   // ***************************************************************
   // write channel handshake
   // ***************************************************************
   assign AWREADY_O = !aw_held && !bvalid;
   assign WREADY_O  = !w_held && !bvalid;
   assign wr_fire   = aw_held && w_held && !bvalid;

   always_comb begin
      integer b;
      b = 0;
      wr_bits = '0;
      for (b = 0; b < 4; b++) begin
         wr_bits[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : 8'h00;
      end
   end

   // ***************************************************************
   // write address and data holding
   // ***************************************************************
   // a new write waits until the previous response has been taken
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      if (AWVALID_I && AWREADY_O) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR_I[bsm_pkg::ADDR_W-1:0];
      end
      if (WVALID_I && WREADY_O) begin
         next_w_held = 1'b1;
         next_w_data = WDATA_I;
         next_w_strb = WSTRB_I;
      end
      // both halves are spent together when the write executes
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held  <= 1'b0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held  <= next_w_held;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
      end
   end

   // ***************************************************************
   // write execution and response
   // ***************************************************************
   always_comb begin
      next_bvalid     = bvalid;
      next_bresp      = bresp;
      next_irq_enable = irq_enable;
      box_clear       = '0;
      if (wr_fire) begin
         next_bvalid = 1'b1;
         next_bresp  = bsm_pkg::RESP_OKAY;
         if (wr_hit_status) begin // RL9
            // mirrored bits ignore writes, only box flags clear
            box_clear = wr_bits[bsm_pkg::BOX_FLAG_LSB +: bsm_pkg::NUM_BOXES]; // RL2 RL5
         end else if (wr_hit_enable) begin
            next_irq_enable = wr_bits & bsm_pkg::IRQ_IMPL_MASK; // RL11
         end else if (wr_hit_current) begin
            // read-only, write accepted and dropped
            next_bresp = bsm_pkg::RESP_OKAY; // RL6
         end else begin
            next_bresp = bsm_pkg::RESP_SLVERR;
         end
      end
      if (bvalid && BREADY_I) begin
         next_bvalid = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         bvalid     <= 1'b0;
         bresp      <= bsm_pkg::RESP_OKAY;
         irq_enable <= bsm_pkg::RESET_WORD;
      end else begin
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         irq_enable <= next_irq_enable;
      end
   end

   assign BVALID_O = bvalid;
   assign BRESP_O  = bresp;

   // ***************************************************************
   // mailbox written flags
   // ***************************************************************
   bsm_box_flags #(
      .N (bsm_pkg::NUM_BOXES)
   ) u_box_flags (
      .CORE_CLK_I (CORE_CLK_I),
      .RSTN_I     (RSTN_I),
      .set_i      (BOX_WRITE_I), // RL4
      .clear_i    (box_clear),
      .flag_o     (box_flag)
   );

   // ***************************************************************
   // read channel
   // ***************************************************************
   assign ARREADY_O = !rvalid;

   always_comb begin
      next_rvalid    = rvalid;
      next_rd_answer = rd_answer;
      if (ARVALID_I && ARREADY_O) begin
         next_rvalid         = 1'b1;
         next_rd_answer.resp = bsm_pkg::RESP_OKAY;
         // mirrors and flags are taken live at the edge that accepts the address
         if (!rd_upper_zero) begin
            next_rd_answer.data = '0;
            next_rd_answer.resp = bsm_pkg::RESP_SLVERR;
         end else if (rd_hit_status) begin
            next_rd_answer.data = irq_status; // RL9
         end else if (rd_hit_current) begin
            next_rd_answer.data = cur_status; // RL6
         end else if (rd_hit_enable) begin
            next_rd_answer.data = irq_enable;
         end else begin
            next_rd_answer.data = '0;
            next_rd_answer.resp = bsm_pkg::RESP_SLVERR;
         end
      end else if (rvalid && RREADY_I) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rvalid    <= 1'b0;
         rd_answer <= '0;
      end else begin
         rvalid    <= next_rvalid;
         rd_answer <= next_rd_answer;
      end
   end

   assign RVALID_O = rvalid;
   assign RDATA_O  = rd_answer.data;
   assign RRESP_O  = rd_answer.resp;

   // ***************************************************************
   // interrupt output
   // ***************************************************************
   logic [31:0] irq_pending;
   logic        irq;
   logic        next_irq;

   // registered so the line cannot glitch while status and enable settle
   always_comb begin
      irq_pending = irq_status & irq_enable; // RL10
      next_irq    = |irq_pending;
   end

   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   assign CTRL_IRQ_OUT_O = irq;

endmodule

// ==== bsm_top_props.sv ====
// concurrent checks on the ports of the register bank
`timescale 1ns/1ps
module bsm_top_props #(
   parameter bit TARGET_ONLY = 1'b0
) (
   input wire logic                     CORE_CLK_I,
   input wire logic                     RSTN_I,
   input wire bsm_pkg::bsm_pci_cfg_type PCI_CFG_I,
   input wire logic [7:0]               BOX_WRITE_I,
   input wire logic                     AWVALID_I,
   input wire logic                     AWREADY_O,
   input wire logic                     WVALID_I,
   input wire logic                     WREADY_O,
   input wire logic                     BVALID_O,
   input wire logic                     BREADY_I,
   input wire logic [1:0]               BRESP_O,
   input wire logic                     ARVALID_I,
   input wire logic                     ARREADY_O,
   input wire logic [31:0]              ARADDR_I,
   input wire logic                     RVALID_O,
   input wire logic                     RREADY_I,
   input wire logic [31:0]              RDATA_O
);
   logic ar_st;
   logic ar_cur;
   assign ar_st  = ARVALID_I && ARREADY_O && ARADDR_I == 32'h0000_3060;
   assign ar_cur = ARVALID_I && ARREADY_O && ARADDR_I == 32'h0000_306c;
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   chk_rd_latency: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
      else $error("read answer late");
   chk_rd_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read answer dropped");
   chk_wr_latency: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
      |=> !BVALID_O ##1 BVALID_O) else $error("write answer off time");
   chk_wr_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write answer dropped");
   chk_serr_mirror: assert property (ar_st |=>
      RDATA_O[12] == $past(PCI_CFG_I.cfg_status[14])) else $error("bit 12 wrong");
   chk_perr_mirror: assert property (ar_st |=>
      RDATA_O[13] == $past(PCI_CFG_I.cfg_status[15])) else $error("bit 13 wrong");
   chk_master_en: assert property (ar_cur |=> RDATA_O[31:4] == 28'h0 &&
      RDATA_O[3] == (!TARGET_ONLY && $past(PCI_CFG_I.cmd[2])) && RDATA_O[2:0] == 3'h0)
      else $error("current status wrong");
   chk_box_set: assert property (ar_st && $past(BOX_WRITE_I) != 8'h00 |=>
      (RDATA_O[23:16] & $past(BOX_WRITE_I, 2)) == $past(BOX_WRITE_I, 2))
      else $error("mailbox flag missing");
endmodule

bind bsm_top bsm_top_props #(.TARGET_ONLY(TARGET_ONLY)) u_props (.CORE_CLK_I, .RSTN_I,
   .PCI_CFG_I, .BOX_WRITE_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BVALID_O,
   .BREADY_I, .BRESP_O, .ARVALID_I, .ARREADY_O, .ARADDR_I, .RVALID_O, .RREADY_I, .RDATA_O);

// ==== bsm_pci_agent.sv ====
// model of the pci side: config state and inbound mailbox write pulses
`timescale 1ns/1ps
module bsm_pci_agent (
   input  wire logic               clk_i,
   output bsm_pkg::bsm_pci_cfg_type cfg_o,
   output logic [7:0]               box_o
);
   initial begin
      cfg_o = '0;
      box_o = 8'h00;
   end
   task set_cfg(input logic [15:0] s, input logic [15:0] c);
      @(posedge clk_i);
      cfg_o <= {s, c};
   endtask
   // one-cycle pulse per written mailbox
   task write_box(input logic [7:0] m);
      @(posedge clk_i);
      box_o <= m;
      @(posedge clk_i);
      box_o <= 8'h00;
   endtask
endmodule

// ==== bridge_status_mailbox_flags_tb.sv ====
// self-checking bench for the bridge status mailbox flags block
`timescale 1ns/1ps
module bridge_status_mailbox_flags_tb;
   logic                     clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic                     awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0]              awaddr, wdata, araddr, rdata, got, rdata_t, got_t;
   logic [3:0]               wstrb;
   logic [1:0]               bresp, rresp, resp;
   logic [7:0]               box, flags, m, c;
   logic [15:0]              st, cmd;
   bsm_pkg::bsm_pci_cfg_type cfg;
   int                       errors, n_compared, seed;
   bsm_pci_agent agent (.clk_i(clk), .cfg_o(cfg), .box_o(box));
   bsm_top dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .PCI_CFG_I(cfg), .BOX_WRITE_I(box),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr), .AWPROT_I(3'h0),
      .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
      .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .ARADDR_I(araddr), .ARPROT_I(3'h0), .RVALID_O(rvalid),
      .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp), .CTRL_IRQ_OUT_O(irq));
   // target-only twin sees the same bus and answers in lock step
   bsm_top #(.TARGET_ONLY(1'b1)) dut_tgt (.CORE_CLK_I(clk), .RSTN_I(rstn), .PCI_CFG_I(cfg),
      .BOX_WRITE_I(box), .AWVALID_I(awvalid), .AWREADY_O(), .AWADDR_I(awaddr), .AWPROT_I(3'h0),
      .WVALID_I(wvalid), .WREADY_O(), .WDATA_I(wdata), .WSTRB_I(wstrb), .BVALID_O(),
      .BREADY_I(bready), .BRESP_O(), .ARVALID_I(arvalid), .ARREADY_O(), .ARADDR_I(araddr),
      .ARPROT_I(3'h0), .RVALID_O(), .RREADY_I(rready), .RDATA_O(rdata_t), .RRESP_O(),
      .CTRL_IRQ_OUT_O());
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ***************************************************************
   // bus tasks and expectations
   // ***************************************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task hang;
      errors++;
      $display("Error at %0t: no answer", $time);
      test_done;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 50) hang;
      resp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [31:0] a);
      int i;
      @(posedge clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 50) hang;
      got = rdata;
      got_t = rdata_t;
      resp = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [31:0] exp_st(input logic [15:0] s, input logic [7:0] f);
      return {8'h00, f, 2'b00, s[15], s[14], 12'h000};
   endfunction
   task irq_is(input logic e);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, {31'h0, e});
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      int k;
      seed = 32'h242a; errors = 0; n_compared = 0; flags = 8'h00;
      rstn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = '0; wdata = '0; araddr = '0; wstrb = 4'h0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      rd(32'h0000_3060); check(got, 32'h0);
      rd(32'h0000_3070); check(got, 32'h0);
      for (k = 0; k < 6; k++) begin
         st = 16'($random(seed));
         cmd = 16'($random(seed));
         agent.set_cfg(st, cmd);
         wr(32'h0000_3060, 32'hffff_ffff, 4'hf);
         rd(32'h0000_3060); check(got, exp_st(st, flags));
         wr(32'h0000_306c, 32'hffff_ffff, 4'hf);
         rd(32'h0000_306c); check(got, {28'h0, cmd[2], 3'h0});
         check(got_t, 32'h0);
      end
      wr(32'h0000_3070, 32'hffff_ffff, 4'h4);
      rd(32'h0000_3070); check(got, 32'h00ff_0000);
      for (k = 0; k < 8; k++) begin
         m = (8'h01 << k) | 8'($random(seed));
         // the address is taken one edge after the pulse, so the flag is fresh
         fork
            agent.write_box(m);
            begin
               @(posedge clk);
               rd(32'h0000_3060);
            end
         join
         flags |= m;
         check(got, exp_st(st, flags));
         irq_is(1'b1);
         c = 8'($random(seed));
         wr(32'h0000_3060, {8'h00, c, 16'h0000}, 4'hf); flags &= ~c;
         rd(32'h0000_3060); check(got, exp_st(st, flags));
         irq_is(|flags);
      end
      // a mailbox write in the very cycle of its clear keeps the flag
      fork
         begin
            @(posedge clk);
            agent.write_box(8'h0f);
         end
         wr(32'h0000_3060, 32'h000f_0000, 4'hf);
      join
      flags |= 8'h0f;
      rd(32'h0000_3060); check(got, exp_st(st, flags));
      agent.write_box(8'hff);
      wr(32'h0000_3070, 32'h0, 4'hf); irq_is(1'b0);
      wr(32'h0000_3070, 32'h0000_3000, 4'hf);
      agent.set_cfg(16'h4000, 16'h0004); irq_is(1'b1);
      rd(32'h0000_3064); check(got, 32'h0); check({30'h0, resp}, {30'h0, bsm_pkg::RESP_SLVERR});
      rd(32'h0001_3060); check({30'h0, resp}, {30'h0, bsm_pkg::RESP_SLVERR});
      wr(32'h0000_306c, 32'h0, 4'hf); check({30'h0, resp}, {30'h0, bsm_pkg::RESP_OKAY});
      rd(32'h0000_306c); check(got, 32'h0000_0008);
      check(got_t, 32'h0);
      test_done;
   end
   initial begin
      repeat (20000) @(posedge clk);
      hang;
   end
endmodule
